/* design/sus_pkg.sv */
// shared constants and types for the serial unit select block
package sus_pkg;
    localparam int UNITS = 2; // two identical serial units
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_BAUD_LOW = 8'hC0;
    localparam logic [7:0] IDX_BAUD_HIGH = 8'hC1;
    localparam logic [7:0] IDX_LINE_CTL = 8'hC3;
    localparam logic [7:0] IDX_OWN_ADDR = 8'hC8;
    localparam logic [7:0] IDX_EXT_ADDR = 8'hC9;
    localparam logic [7:0] IDX_CLK_CTL = 8'hCA;
    localparam logic [7:0] IDX_SOFT_RST = 8'hCD;
    localparam logic [7:0] IDX_SLAVE_STAT = 8'hCE;
    localparam logic [7:0] IDX_UNIT_CTL = 8'hCF;
    localparam logic [7:0] UNIT_STRIDE = 8'h10; // unit 1 sits 0x10 above unit 0
    // reset values
    localparam logic [1:0] RST_UNIT_CTL = 2'h0;
    localparam logic [7:0] RST_LINE_CTL = 8'h00;
    localparam logic [15:0] RST_BAUD = 16'h0002;
    localparam logic [7:0] RST_OWN_ADDR = 8'h00;
    localparam logic [7:0] RST_EXT_ADDR = 8'h00;
    localparam logic [7:0] RST_CLK_CTL = 8'h00;
    // field positions
    localparam int LINE_DIV_ACCESS_BIT = 7;
    localparam int GC_ENABLE_BIT = 0;
    localparam int SAMPLE_SEL_LSB = 0; // clock control bits 2..0
    localparam int BUSCLK_SEL_LSB = 3; // clock control bits 6..3
    // serial function select encodings
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_UART = 2'h1;
    localparam logic [1:0] MODE_SPI = 2'h2;
    localparam logic [1:0] MODE_I2C = 2'h3;
    // address patterns
    localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;
    localparam logic [7:0] GENERAL_CALL_ADDR = 8'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // address recogniser states
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR1, ST_ADDR2, ST_SLAVE, ST_IGNORE
    } sus_match_state_t;
endpackage : sus_pkg

/* design/sus_match_if.sv */
// link between the unit register logic and its address recogniser
`timescale 1ns/1ps
interface sus_match_if;
    logic sample_en; // bus sampling enable pulse
    logic clear; // engine reset: soft reset or engine deselected
    logic scl; // bus clock level
    logic sda; // bus data level
    logic [7:0] own_address; // own-address register
    logic [7:0] ext_address; // extended own-address register
    logic sda_drive; // pull data low for acknowledge
    logic addressed; // engine is in slave mode
    logic event_pulse; // one-cycle addressed event
    logic general_call; // last match was general call
    logic ten_bit_wait; // first ten-bit byte accepted
    modport engine (input sample_en, clear, scl, sda, own_address, ext_address,
        output sda_drive, addressed, event_pulse, general_call, ten_bit_wait);
    modport ctrl (output sample_en, clear, scl, sda, own_address, ext_address,
        input sda_drive, addressed, event_pulse, general_call, ten_bit_wait);
endinterface : sus_match_if

/* design/sus_addr_match.sv */
// two-wire slave address recogniser for one serial unit
`timescale 1ns/1ps
module sus_addr_match (
    input wire logic clk,
    input wire logic rst,
    sus_match_if.engine mif
);
    import sus_pkg::*;

    sus_match_state_t state; // recogniser state
    logic scl_q, scl_p, sda_q, sda_p; // current and previous samples
    logic fresh; // samples were updated last cycle
    logic [7:0] shreg; // received byte, first bit lands at bit 7
    logic [3:0] bit_cnt; // bits received in this byte
    logic ack_phase; // inside the ninth clock
    logic [1:0] first_hi; // address bits 9..8 from the first ten-bit byte
    logic drive, event_q, gc_q; // registered outputs

    // sample the bus on the enable; slow sampling misses short start/stop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {scl_q, scl_p, sda_q, sda_p} <= 4'hF;
            fresh <= 1'b0;
        end else if (mif.clear) begin
            {scl_q, scl_p, sda_q, sda_p} <= 4'hF; // idle bus reads high
            fresh <= 1'b0;
        end else begin
            fresh <= mif.sample_en; // [RL14]
            if (mif.sample_en) begin
                scl_p <= scl_q;
                scl_q <= mif.scl;
                sda_p <= sda_q;
                sda_q <= mif.sda;
            end
        end
    end

    // bus conditions from two consecutive samples
    wire start_cond = fresh & scl_q & scl_p & sda_p & ~sda_q;
    wire stop_cond = fresh & scl_q & scl_p & ~sda_p & sda_q;
    wire scl_rise = fresh & ~scl_p & scl_q;
    wire scl_fall = fresh & scl_p & ~scl_q;
    wire receiving = (state == ST_ADDR1) | (state == ST_ADDR2);
    wire byte_done = (bit_cnt == BITS_PER_BYTE);
    // address comparisons
    wire hit7 = (shreg[7:1] == mif.own_address[7:1]); // [RL7]
    wire ten_prefix = (mif.own_address[7:3] == TEN_BIT_PREFIX); // [RL9]
    wire hit10a = ten_prefix & hit7; // [RL9]
    wire hit_gc = (shreg == GENERAL_CALL_ADDR) & mif.own_address[GC_ENABLE_BIT]; // [RL13]
    wire [9:0] ten_addr = {mif.own_address[2:1], mif.ext_address}; // [RL12]
    wire hit10b = ({first_hi, shreg} == ten_addr); // [RL12]
    wire accept = ((state == ST_ADDR1) & (hit10a | (hit7 & ~ten_prefix) | hit_gc))
        | ((state == ST_ADDR2) & hit10b);

    // byte reception, acknowledge and state changes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            shreg <= 8'h00;
            bit_cnt <= 4'h0;
            ack_phase <= 1'b0;
            first_hi <= 2'h0;
            drive <= 1'b0;
            event_q <= 1'b0;
            gc_q <= 1'b0;
        end else if (mif.clear) begin
            state <= ST_IDLE; // [RL16]
            bit_cnt <= 4'h0;
            ack_phase <= 1'b0;
            drive <= 1'b0;
            event_q <= 1'b0;
            gc_q <= 1'b0;
        end else begin
            event_q <= 1'b0;
            if (start_cond) begin
                // start or repeated start: next byte is an address
                state <= ST_ADDR1;
                bit_cnt <= 4'h0;
                ack_phase <= 1'b0;
                drive <= 1'b0;
                gc_q <= 1'b0;
            end else if (stop_cond) begin
                state <= ST_IDLE;
                bit_cnt <= 4'h0;
                ack_phase <= 1'b0;
                drive <= 1'b0;
            end else if (scl_rise & receiving & ~ack_phase & ~byte_done) begin
                shreg <= {shreg[6:0], sda_q}; // [RL8]
                bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall & receiving & byte_done & ~ack_phase) begin
                ack_phase <= 1'b1;
                drive <= accept; // [RL10]
            end else if (scl_fall & ack_phase) begin
                ack_phase <= 1'b0;
                drive <= 1'b0;
                bit_cnt <= 4'h0;
                case (state)
                    ST_ADDR1: begin
                        if (!drive) begin
                            state <= ST_IGNORE;
                        end else if (hit10a) begin
                            state <= ST_ADDR2; // [RL10]
                            first_hi <= shreg[2:1];
                        end else begin
                            state <= ST_SLAVE; // [RL7]
                            event_q <= 1'b1;
                            gc_q <= hit_gc;
                        end
                    end
                    ST_ADDR2: begin
                        state <= drive ? ST_SLAVE : ST_IGNORE; // [RL11]
                        event_q <= drive; // [RL11]
                    end
                    default: begin
                        state <= state;
                    end
                endcase
            end
        end
    end

    assign mif.sda_drive = drive;
    assign mif.addressed = (state == ST_SLAVE);
    assign mif.event_pulse = event_q;
    assign mif.general_call = gc_q;
    assign mif.ten_bit_wait = (state == ST_ADDR2);

    AST_NO_EVENT_FIRST_TEN: assert property (@(posedge clk) disable iff (rst) // [RL10]
        $rose(mif.ten_bit_wait) |-> !mif.event_pulse)
        else $error("event raised on first ten-bit byte");
    AST_EVENT_MEANS_SLAVE: assert property (@(posedge clk) disable iff (rst) // [RL11]
        mif.event_pulse |-> mif.addressed && $past(ack_phase))
        else $error("event without entering slave mode");
    AST_EVENT_ONE_CYCLE: assert property (@(posedge clk) disable iff (rst) // [RL7]
        mif.event_pulse |=> !mif.event_pulse)
        else $error("event longer than one cycle");
    AST_GC_NEEDS_ENABLE: assert property (@(posedge clk) disable iff (rst) // [RL13]
        $rose(mif.general_call) |-> $past(mif.own_address[GC_ENABLE_BIT]))
        else $error("general call taken while disabled");
    AST_ACK_IN_NINTH: assert property (@(posedge clk) disable iff (rst) // [RL10]
        drive |-> ack_phase && byte_done)
        else $error("acknowledge outside ninth clock");
    AST_CLEAR_IDLES: assert property (@(posedge clk) disable iff (rst) // [RL16]
        mif.clear |=> state == ST_IDLE && !drive)
        else $error("clear did not idle the engine");
    COV_SEVEN_BIT: cover property (@(posedge clk) disable iff (rst)
        mif.event_pulse && !mif.general_call);
    COV_TEN_BIT: cover property (@(posedge clk) disable iff (rst)
        $past(mif.ten_bit_wait) && mif.event_pulse);
endmodule : sus_addr_match

/* design/sus_top.sv */
// register front end of the two serial units with two-wire address recognition
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ps
// Functional notes
// [RL1] function select: off, async, sync, two-wire
// [RL2] each unit owns its own control register
// [RL3] sixteen-bit baud divider resets to two
// [RL4] software keeps divider at two or more
// [RL5] divider byte write reloads and restarts counter
// [RL6] divider reachable only with line control bit7
// [RL7] seven-bit address match enters slave mode
// [RL8] own-address bit 7 meets first bus bit
// [RL9] prefix 11110b starts ten-bit address sequence
// [RL10] first ten-bit byte acked, no event
// [RL11] second ten-bit byte match raises event
// [RL12] ten-bit address is own[2:1] over extended
// [RL13] general call answered only when enabled
// [RL14] sampling rate ten times fastest bus clock
// [RL15] sample and bus clock from clock control
// [RL16] any soft reset write resets two-wire engine
// [RL17] control upper six bits read zero
// [RL18] only selected engine drives the shared pins
module sus_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [sus_pkg::UNITS-1:0] i2c_scl_in,
    input wire logic [sus_pkg::UNITS-1:0] i2c_sda_in,
    output logic [sus_pkg::UNITS-1:0] i2c_scl_out,
    output logic [sus_pkg::UNITS-1:0] i2c_scl_oe,
    output logic [sus_pkg::UNITS-1:0] i2c_sda_out,
    output logic [sus_pkg::UNITS-1:0] i2c_sda_oe,
    output logic [sus_pkg::UNITS-1:0] uart_enable,
    output logic [sus_pkg::UNITS-1:0] spi_enable,
    output logic [sus_pkg::UNITS-1:0] i2c_enable,
    output logic [sus_pkg::UNITS-1:0] baud_tick,
    output logic [sus_pkg::UNITS-1:0] bus_sample_tick,
    output logic [sus_pkg::UNITS-1:0] bus_clock_tick,
    output logic [sus_pkg::UNITS-1:0] slave_addressed,
    output logic [sus_pkg::UNITS-1:0] slave_event
);
    import sus_pkg::*;

    // index of a unit's copy of a register
    function automatic logic [7:0] unit_idx(input logic [7:0] base, input int unit);
        unit_idx = base + 8'(unit) * UNIT_STRIDE;
    endfunction : unit_idx

    logic ack_q; // second cycle of an access
    logic [UNITS-1:0][7:0] unit_rdata; // per-unit read contributions
    wire access = avs_read | avs_write; // any request pending
    wire [7:0] idx = avs_address[9:2]; // word index of the access
    wire wr_go = avs_write & ack_q & avs_byteenable[0]; // write commits here
    wire rd_capture = avs_read & ~ack_q; // read data latched here
    wire [7:0] wbyte = avs_writedata[7:0]; // registers use the low lane

    // fixed one-wait-state answer keeps decode off the critical path
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= access & ~ack_q;
        end
    end
    assign avs_waitrequest = access & ~ack_q;

    // read data stands from the waitrequest-low edge; unmapped reads zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            avs_readdata <= 32'h00000000;
        end else if (rd_capture) begin
            avs_readdata <= {24'h000000, unit_rdata[0] | unit_rdata[1]};
        end
    end

    genvar u;
    generate
        for (u = 0; u < UNITS; u++) begin : g_unit
            logic [1:0] mode; // serial function select
            logic [7:0] line_ctl; // line control
            logic [15:0] divider; // baud divider high and low
            logic [15:0] baud_cnt; // baud down counter
            logic [7:0] own_addr; // own address
            logic [7:0] ext_addr; // extended own address
            logic [7:0] clk_ctl; // bus clock control
            logic [7:0] sample_cnt; // sample prescaler
            logic [3:0] busclk_cnt; // sample ticks per bus clock tick
            logic baud_q, sample_q, busclk_q; // registered ticks
            sus_match_if mif ();

            // register decode for this unit
            wire sel_ctl = (idx == unit_idx(IDX_UNIT_CTL, u)); // [RL2]
            wire sel_line = (idx == unit_idx(IDX_LINE_CTL, u));
            wire sel_low = (idx == unit_idx(IDX_BAUD_LOW, u));
            wire sel_high = (idx == unit_idx(IDX_BAUD_HIGH, u));
            wire sel_own = (idx == unit_idx(IDX_OWN_ADDR, u));
            wire sel_ext = (idx == unit_idx(IDX_EXT_ADDR, u));
            wire sel_ccr = (idx == unit_idx(IDX_CLK_CTL, u));
            wire sel_srr = (idx == unit_idx(IDX_SOFT_RST, u));
            wire sel_stat = (idx == unit_idx(IDX_SLAVE_STAT, u));
            wire div_open = line_ctl[LINE_DIV_ACCESS_BIT]; // [RL6]
            wire baud_wr = wr_go & div_open & (sel_low | sel_high); // [RL5]
            wire soft_rst = wr_go & sel_srr; // [RL16]
            wire uart_on = (mode == MODE_UART); // [RL1]
            wire spi_on = (mode == MODE_SPI); // [RL1]
            wire i2c_on = (mode == MODE_I2C); // [RL1]
            wire [15:0] next_divider = sel_low ? {divider[15:8], wbyte} // [RL5]
                : {wbyte, divider[7:0]};
            wire [7:0] sample_mask = (8'h01 << clk_ctl[SAMPLE_SEL_LSB +: 3]) - 8'h01; // [RL15]
            wire sample_hit = ((sample_cnt & sample_mask) == sample_mask);
            wire [3:0] busclk_lim = clk_ctl[BUSCLK_SEL_LSB +: 4]; // [RL15]

            // software-written registers
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    mode <= RST_UNIT_CTL;
                    line_ctl <= RST_LINE_CTL;
                    divider <= RST_BAUD; // [RL3]
                    own_addr <= RST_OWN_ADDR;
                    ext_addr <= RST_EXT_ADDR;
                    clk_ctl <= RST_CLK_CTL;
                end else if (wr_go) begin
                    if (sel_ctl) begin
                        mode <= wbyte[1:0]; // [RL17]
                    end
                    if (sel_line) begin
                        line_ctl <= wbyte;
                    end
                    if (baud_wr) begin
                        divider <= next_divider; // [RL6]
                    end
                    if (sel_own) begin
                        own_addr <= wbyte;
                    end
                    if (sel_ext) begin
                        ext_addr <= wbyte;
                    end
                    if (sel_ccr) begin
                        clk_ctl <= wbyte;
                    end
                end
            end

            // baud counter; divider below two gives no defined rate
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    baud_cnt <= RST_BAUD;
                    baud_q <= 1'b0;
                end else if (baud_wr) begin
                    baud_cnt <= next_divider; // [RL5]
                    baud_q <= 1'b0;
                end else if (uart_on | spi_on) begin
                    baud_q <= (baud_cnt <= 16'h0001); // [RL4]
                    baud_cnt <= (baud_cnt <= 16'h0001) ? divider : baud_cnt - 16'h0001;
                end else begin
                    baud_q <= 1'b0;
                end
            end

            // sampling and bus clock enables, only while two-wire is selected
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    sample_cnt <= 8'h00;
                    busclk_cnt <= 4'h0;
                    sample_q <= 1'b0;
                    busclk_q <= 1'b0;
                end else if (!i2c_on || soft_rst) begin
                    sample_cnt <= 8'h00;
                    busclk_cnt <= 4'h0;
                    sample_q <= 1'b0;
                    busclk_q <= 1'b0;
                end else begin
                    sample_cnt <= sample_cnt + 8'h01;
                    sample_q <= sample_hit; // [RL15]
                    busclk_q <= sample_hit & (busclk_cnt == busclk_lim);
                    if (sample_hit) begin
                        busclk_cnt <= (busclk_cnt == busclk_lim) ? 4'h0 : busclk_cnt + 4'h1;
                    end
                end
            end

            // deselected engine is held cleared and sees an idle bus
            assign mif.sample_en = sample_q;
            assign mif.clear = soft_rst | ~i2c_on; // [RL18]
            assign mif.scl = i2c_scl_in[u];
            assign mif.sda = i2c_sda_in[u];
            assign mif.own_address = own_addr;
            assign mif.ext_address = ext_addr;

            sus_addr_match u_match (
                .clk(clk),
                .rst(rst),
                .mif(mif)
            );

            // shared pins: open drain, only the two-wire engine pulls them
            assign i2c_sda_out[u] = 1'b0;
            assign i2c_sda_oe[u] = i2c_on & mif.sda_drive; // [RL18]
            assign i2c_scl_out[u] = 1'b0;
            assign i2c_scl_oe[u] = 1'b0; // no clock stretching
            assign uart_enable[u] = uart_on;
            assign spi_enable[u] = spi_on;
            assign i2c_enable[u] = i2c_on;
            assign baud_tick[u] = baud_q;
            assign bus_sample_tick[u] = sample_q;
            assign bus_clock_tick[u] = busclk_q;
            assign slave_addressed[u] = mif.addressed;
            assign slave_event[u] = mif.event_pulse;

            // read selection; locked divider and soft reset read zero
            assign unit_rdata[u] = sel_ctl ? {6'h00, mode} // [RL17]
                : sel_line ? line_ctl
                : (sel_low & div_open) ? divider[7:0] // [RL6]
                : (sel_high & div_open) ? divider[15:8] // [RL6]
                : sel_own ? own_addr
                : sel_ext ? ext_addr
                : sel_ccr ? clk_ctl
                : sel_stat ? {5'h00, mif.ten_bit_wait, mif.general_call, mif.addressed}
                : 8'h00;

            AST_BAUD_RESTART: assert property (@(posedge clk) disable iff (rst) // [RL5]
                baud_wr |=> baud_cnt == divider && !baud_q)
                else $error("divider write did not restart counter");
            AST_DIV_LOCKED: assert property (@(posedge clk) disable iff (rst) // [RL6]
                wr_go && (sel_low || sel_high) && !div_open |=> $stable(divider))
                else $error("divider changed while locked");
            AST_ONE_ENGINE: assert property (@(posedge clk) disable iff (rst) // [RL1]
                $onehot0({uart_on, spi_on, i2c_on}) && (mode == MODE_OFF) == !(uart_on
                || spi_on || i2c_on))
                else $error("engine selection not exclusive");
            AST_PINS_QUIET: assert property (@(posedge clk) disable iff (rst) // [RL18]
                !i2c_on |-> !i2c_sda_oe[u] ##1 !mif.addressed)
                else $error("deselected engine active on bus");
            AST_SOFT_RESET: assert property (@(posedge clk) disable iff (rst) // [RL16]
                soft_rst |=> !mif.addressed && !mif.sda_drive)
                else $error("soft reset did not reset engine");
            COV_BAUD: cover property (@(posedge clk) disable iff (rst) baud_wr ##[1:20] baud_q);
        end
    endgenerate

    AST_WAIT_ONE: assert property (@(posedge clk) disable iff (rst)
        access && !avs_waitrequest |-> $past(access) && $past(avs_waitrequest))
        else $error("answer not after exactly one wait cycle");
endmodule : sus_top

/* testbench/sus_i2c_master.sv */
// two-wire bus master model facing one serial unit
`timescale 1ns/1ps
module sus_i2c_master (
    input wire logic clk,
    input wire logic sda_bus,
    output logic scl,
    output logic sda_rel
);
    // idle bus: both lines released to the pull-up
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    // third of a bit of four clocks, well above the sampling need
    task automatic hc();
        repeat (4) @(posedge clk);
    endtask : hc
    // start: data falls while clock is high
    task automatic start();
        sda_rel <= 1'b1;
        scl <= 1'b1;
        hc();
        sda_rel <= 1'b0;
        hc();
        scl <= 1'b0;
        hc();
    endtask : start
    // stop: data rises while clock is high
    task automatic stop();
        sda_rel <= 1'b0;
        hc();
        scl <= 1'b1;
        hc();
        sda_rel <= 1'b1;
        hc();
    endtask : stop
    // byte msb first, then data released and acknowledge sampled
    task automatic send(input logic [7:0] b, output logic ack);
        for (int i = 8; i >= 0; i--) begin
            sda_rel <= (i == 0) ? 1'b1 : b[i-1];
            hc();
            scl <= 1'b1;
            hc();
            ack = ~sda_bus;
            scl <= 1'b0;
            hc();
        end
    endtask : send
endmodule : sus_i2c_master

/* testbench/test_serial_unit_select_i2c_slave_addr.sv */
// register bus and two-wire bench for the serial unit select block
`timescale 1ns/1ps
module test_serial_unit_select_i2c_slave_addr;
    import sus_pkg::*;
    `define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin miscompares++; \
        $display("Error %s expected %h seen %h", n, e, s); end end
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [9:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [UNITS-1:0] sda_oe, uart_en, spi_en, i2c_en, baud_tick, addressed, event_p;
    logic [UNITS-1:0] scl_oe, sda_o, scl_o, smp, bck;
    wire [2:0] tk = {bck[0], smp[0], baud_tick[0]}; // ticks that period can time
    logic scl, sda_rel, ack;
    logic [7:0] rd; // last read byte
    logic [7:0] nak [3] = '{8'hA6, 8'h24, 8'h00}; // near misses and general call
    int events = 0, cycles = 0, compares = 0, miscompares = 0, n;
    always #5 clk = ~clk;
    sus_i2c_master m (.clk(clk), .sda_bus(sda_rel & ~sda_oe[0]), .scl(scl), .sda_rel(sda_rel));
    sus_top dut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .i2c_scl_in({1'b1, scl}), .i2c_sda_in({1'b1, sda_rel & ~sda_oe[0]}),
        .i2c_scl_out(scl_o), .i2c_scl_oe(scl_oe), .i2c_sda_out(sda_o), .i2c_sda_oe(sda_oe),
        .uart_enable(uart_en), .spi_enable(spi_en), .i2c_enable(i2c_en),
        .baud_tick(baud_tick), .bus_sample_tick(smp), .bus_clock_tick(bck),
        .slave_addressed(addressed), .slave_event(event_p));
    // event count and hang guard; the ceiling is far past the run length
    always @(posedge clk) begin
        cycles++;
        if (event_p[0] === 1'b1) events++;
        if (cycles > 20000) begin
            miscompares++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    // one access, held until waitrequest is seen low
    task automatic acc(input logic [7:0] idx, input logic w, input logic [7:0] d);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h0, d};
        avs_write <= w;
        avs_read <= ~w;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        rd = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask : acc
    task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
        acc(idx, 1'b0, 8'h00);
        `CHK($sformatf("reg %h", idx), e, rd)
    endtask : rdc
    // clocks between two ticks of unit 0; the first tick seen may be from the old setting
    task automatic period(input int s, output int p);
        repeat (2) begin
            @(posedge clk);
            while (tk[s] !== 1'b1) @(posedge clk);
        end
        @(posedge clk);
        p = 1;
        while (tk[s] !== 1'b1) begin
            @(posedge clk);
            p++;
        end
    endtask : period
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdc(IDX_UNIT_CTL, 8'h00);
        rdc(IDX_BAUD_LOW, 8'h00);
        acc(IDX_LINE_CTL, 1'b1, 8'h80);
        rdc(IDX_BAUD_LOW, 8'h02);
        rdc(IDX_BAUD_HIGH, 8'h00);
        rdc(8'h05, 8'h00);
        $display("end regs");
        acc(IDX_UNIT_CTL, 1'b1, 8'hFF);
        rdc(IDX_UNIT_CTL, 8'h03);
        for (int k = 0; k < 4; k++) begin
            acc(IDX_UNIT_CTL + UNIT_STRIDE, 1'b1, 8'(k));
            `CHK("mode", {k == 1, k == 2, k == 3}, {uart_en[1], spi_en[1], i2c_en[1]})
            `CHK("unit0", 1'b1, i2c_en[0])
        end
        $display("end modes");
        acc(IDX_UNIT_CTL, 1'b1, 8'(MODE_UART));
        acc(IDX_BAUD_LOW, 1'b1, 8'h05);
        period(0, n);
        `CHK("period", 5, n)
        acc(IDX_BAUD_HIGH, 1'b1, 8'h01);
        period(0, n);
        `CHK("period", 261, n)
        acc(IDX_LINE_CTL, 1'b1, 8'h00);
        rdc(IDX_BAUD_LOW, 8'h00);
        $display("end baud");
        acc(IDX_OWN_ADDR, 1'b1, 8'hA4);
        m.start();
        m.send(8'hA4, ack);
        m.stop();
        `CHK("ack", 1'b0, ack)
        acc(IDX_UNIT_CTL, 1'b1, 8'(MODE_I2C));
        m.start();
        m.send(8'hA4, ack);
        `CHK("ack", 1'b1, ack)
        `CHK("addressed", 1'b1, addressed[0])
        `CHK("events", 1, events)
        m.stop();
        foreach (nak[i]) begin
            m.start();
            m.send(nak[i], ack);
            m.stop();
            `CHK("nak", 1'b0, ack)
        end
        acc(IDX_OWN_ADDR, 1'b1, 8'hA5);
        m.start();
        m.send(8'h00, ack);
        `CHK("gc", 1'b1, ack)
        rdc(IDX_SLAVE_STAT, 8'h03);
        m.stop();
        acc(IDX_OWN_ADDR, 1'b1, 8'hF2);
        acc(IDX_EXT_ADDR, 1'b1, 8'h5A);
        m.start();
        m.send(8'hF2, ack);
        `CHK("ten1", {1'b1, 1'b0, 32'd2}, {ack, addressed[0], events})
        rdc(IDX_SLAVE_STAT, 8'h04);
        m.send(8'h5A, ack);
        `CHK("ten2", {1'b1, 1'b1, 32'd3}, {ack, addressed[0], events})
        acc(IDX_SOFT_RST, 1'b1, 8'h3C);
        `CHK("soft", 1'b0, addressed[0])
        m.stop();
        $display("end bus");
        // sample every 2^2 clocks, bus clock every 1+1 samples
        acc(IDX_CLK_CTL, 1'b1, 8'h0A);
        period(1, n);
        `CHK("sample", 4, n)
        period(2, n);
        `CHK("busclk", 8, n)
        `CHK("pins", 6'h00, {scl_oe, sda_o, scl_o})
        $display("end clocks");
        give_verdict();
    end
endmodule : test_serial_unit_select_i2c_slave_addr
